//--- hw/block_select_reg.v
// write-only block-select register
`timescale 1ns/1ps
module block_select_reg #(
   parameter W = 6
) (
   input  wire         i_clk,
   input  wire         i_we,
   input  wire [W-1:0] i_wdata,
   output wire [W-1:0] o_block
);
   // no reset on purpose: content undefined until first write
   reg [W-1:0] blk_q;
   always @(posedge i_clk) begin
      if (i_we) begin
         blk_q <= i_wdata;
      end
   end
   assign o_block = blk_q;
endmodule

//--- hw/data_rom_window_mapper.v
// data rom window address mapper between core data bus and program memory
`timescale 1ns/1ps
`include "rom_window_regs.vh"
module data_rom_window_mapper #(
   parameter PADDR_W = `WIN_PADDR_W
) (
   // clock and reset
   input  wire               i_clk,
   input  wire               i_nrst,
   // core data bus
   input  wire [7:0]         i_daddr,
   input  wire               i_dwr,
   input  wire               i_drd,
   input  wire [7:0]         i_dwdata,
   // program memory side
   input  wire [7:0]         i_prom_data,
   // decode and translation results
   output wire               o_win_hit,
   output wire               o_sel_hit,
   output wire               o_prom_rd,
   output wire [PADDR_W-1:0] o_prom_addr,
   output wire [7:0]         o_win_rdata
);
   ////////////////////////////////////////////////////////////////
   // sizes and fixed addresses
   localparam DADDR_W = 8;
   localparam DATA_W  = 8;
   localparam OFS_W   = `WIN_OFS_W;
   localparam BLK_W   = `WIN_BLK_W;
   localparam BLK_LO  = OFS_W;
   localparam BLK_HI  = OFS_W + BLK_W - 1;
   localparam RST_N   = `WIN_RST_STAGES;

   localparam [DADDR_W-1:0] WIN_LO  = `WIN_BASE_ADDR;
   localparam [DADDR_W-1:0] WIN_HI  = `WIN_LAST_ADDR;
   localparam [DADDR_W-1:0] SEL_AD  = `WIN_SEL_ADDR;

   localparam [DATA_W-1:0]  RD_IDLE = `WIN_RD_IDLE;

   ////////////////////////////////////////////////////////////////
   // decode helpers
   // true for a data address inside the read-only window
   function in_window;
      input [DADDR_W-1:0] a;
      reg                 above;
      reg                 below;
      begin
         above = (a >= WIN_LO);
         below = (a <= WIN_HI);
         if (above && below) begin
            in_window = 1'h1;
         end else begin
            in_window = 1'h0;
         end
      end
   endfunction

   // true for the block-select location
   function is_select;
      input [DADDR_W-1:0] a;
      begin
         if (a == SEL_AD) begin
            is_select = 1'h1;
         end else begin
            is_select = 1'h0;
         end
      end
   endfunction

   // a select write needs the strobe, the address and a settled reset
   function write_select;
      input hit;
      input wr;
      input ok;
      begin
         if (hit && wr && ok) begin
            write_select = 1'h1;
         end else begin
            write_select = 1'h0;
         end
      end
   endfunction

   // a window read needs the strobe and a window address
   function read_window;
      input hit;
      input rd;
      begin
         if (hit && rd) begin
            read_window = 1'h1;
         end else begin
            read_window = 1'h0;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // field helpers
   // low address bits give the byte inside the block
   function [OFS_W-1:0] offset_of;
      input [DADDR_W-1:0] a;
      begin
         offset_of = a[OFS_W-1:0];
      end
   endfunction

   // reserved bits 7:6 are dropped; software keeps them zero
   function [BLK_W-1:0] block_field;
      input [DATA_W-1:0] d;
      begin
         block_field = d[`WIN_BLK_MSB:0];
      end
   endfunction

   // block number above the offset, so block n starts at n*64;
   // bits above the block field stay zero for a wider bus
   function [PADDR_W-1:0] compose_addr;
      input [BLK_W-1:0] blk;
      input [OFS_W-1:0] ofs;
      integer           i;
      begin
         compose_addr = {PADDR_W{1'h0}};
         for (i = 0; i < OFS_W; i = i + 1) begin
            compose_addr[i] = ofs[i];
         end
         for (i = BLK_LO; i <= BLK_HI; i = i + 1) begin
            compose_addr[i] = blk[i-BLK_LO];
         end
      end
   endfunction

   // idle value keeps the data bus quiet outside window reads
   function [DATA_W-1:0] pick_rdata;
      input              en;
      input [DATA_W-1:0] d;
      begin
         if (en) begin
            pick_rdata = d;
         end else begin
            pick_rdata = RD_IDLE;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   // reset: asserts at once, releases through two flops so the first
   // write strobe never races the release
   reg [RST_N-1:0] rst_q;
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_q <= {RST_N{1'h0}};
      end else begin
         rst_q <= {rst_q[RST_N-2:0], 1'h1};
      end
   end

   wire rst_ok = rst_q[RST_N-1];

   ////////////////////////////////////////////////////////////////
   // address decode
   reg win_hit;
   always @* begin
      win_hit = in_window(i_daddr);
   end

   reg sel_hit;
   always @* begin
      sel_hit = is_select(i_daddr);
   end

   ////////////////////////////////////////////////////////////////
   // select write; strobes inside the sync window are dropped
   reg sel_we;
   always @* begin
      sel_we = write_select(sel_hit, i_dwr, rst_ok);
   end

   reg [BLK_W-1:0] sel_wdata;
   always @* begin
      sel_wdata = block_field(i_dwdata);
   end

   ////////////////////////////////////////////////////////////////
   // block-select register, no reset: undefined until software loads it
   wire [BLK_W-1:0] blk;

   block_select_reg #(
      .W (BLK_W)
   ) u_block_select_reg (
      .i_clk   (i_clk),
      .i_we    (sel_we),
      .i_wdata (sel_wdata),
      .o_block (blk)
   );

   ////////////////////////////////////////////////////////////////
   // translation: combinational so data lands in the core read cycle;
   // the price is a path from the address straight to the data bus
   reg [PADDR_W-1:0] prom_addr;
   always @* begin
      prom_addr = compose_addr(blk, offset_of(i_daddr));
   end

   reg prom_rd;
   always @* begin
      prom_rd = read_window(win_hit, i_drd);
   end

   reg [DATA_W-1:0] win_rdata;
   always @* begin
      win_rdata = pick_rdata(prom_rd, i_prom_data);
   end

   ////////////////////////////////////////////////////////////////
   // outputs
   assign o_prom_addr = prom_addr;
   assign o_prom_rd   = prom_rd;
   assign o_win_rdata = win_rdata;
   assign o_win_hit   = win_hit;
   assign o_sel_hit   = sel_hit;
endmodule

//--- include/rom_window_regs.vh
// constants for the data rom window mapper
`ifndef ROM_WINDOW_REGS_VH
`define ROM_WINDOW_REGS_VH
`define WIN_BASE_ADDR   8'h40
`define WIN_LAST_ADDR   8'h7f
`define WIN_SEL_ADDR    8'hc9
`define WIN_OFS_W       6
`define WIN_BLK_W       6
`define WIN_BLK_MSB     5
`define WIN_PADDR_W     12
`define WIN_RD_IDLE     8'h00
`define WIN_RST_STAGES  2
`endif

//--- testbench/data_rom_window_mapper_asserts.sv
// checker for the rom window mapper
`timescale 1ns/1ps
module win_chk(input wire i_clk,i_nrst,i_dwr,i_drd,o_win_hit,o_sel_hit,
   o_prom_rd,input wire [7:0] i_daddr,i_dwdata,i_prom_data,o_win_rdata,
   input wire [11:0] o_prom_addr);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire wr = i_dwr && o_sel_hit;
   property p_hit; o_win_hit == (i_daddr[7:6] == 2'b01); endproperty
   a_hit: assert property (p_hit) else $error("hit");
   property p_sel; o_sel_hit == (i_daddr == 8'hc9); endproperty
   a_sel: assert property (p_sel) else $error("sel");
   property p_ofs; o_prom_addr[5:0] == i_daddr[5:0]; endproperty
   a_ofs: assert property (p_ofs) else $error("ofs");
   property p_blk;
      wr |=> o_prom_addr[11:6] == $past(i_dwdata[5:0]);
   endproperty
   a_blk: assert property (p_blk) else $error("blk");
   property p_keep; !$stable(o_prom_addr[11:6]) |-> $past(wr); endproperty
   a_keep: assert property (p_keep) else $error("keep");
   property p_dat;
      o_win_rdata == (o_prom_rd ? i_prom_data : 8'h00);
   endproperty
   a_dat: assert property (p_dat) else $error("dat");
   property p_rd; o_prom_rd == (o_win_hit && i_drd); endproperty
   a_rd: assert property (p_rd) else $error("rd");
   property p_seq; wr ##1 o_win_hit |-> o_prom_addr ==
      {$past(i_dwdata[5:0]), i_daddr[5:0]}; endproperty
   a_seq: assert property (p_seq) else $error("seq");
endmodule
bind data_rom_window_mapper win_chk u_win_chk(.*);

//--- testbench/data_rom_window_mapper_tb.sv
// bench for the rom window mapper
`timescale 1ns/1ps
module data_rom_window_mapper_tb;
   reg i_clk=0, i_nrst=0, i_dwr=0, i_drd=0;
   reg [7:0] i_daddr=0, i_dwdata=0;
   wire [7:0] i_prom_data, o_win_rdata;
   wire [11:0] o_prom_addr;
   wire o_win_hit, o_sel_hit, o_prom_rd;
   integer bad_count=0, checks=0, k;
   initial forever #25 i_clk = ~i_clk;
   data_rom_window_mapper u_data_rom_window_mapper(.i_clk(i_clk),
      .i_nrst(i_nrst),.i_daddr(i_daddr),.i_dwr(i_dwr),.i_drd(i_drd),
      .i_dwdata(i_dwdata),.i_prom_data(i_prom_data),.o_win_hit(o_win_hit),
      .o_sel_hit(o_sel_hit),.o_prom_rd(o_prom_rd),
      .o_prom_addr(o_prom_addr),.o_win_rdata(o_win_rdata));
   prom_model u_prom_model(.i_addr(o_prom_addr),.o_data(i_prom_data));
   task cmp(input [7:0] g, e); begin
      checks = checks + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   end endtask
   task cmp_addr(input [11:0] g, e); begin
      checks = checks + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %0t addr got %h want %h", $time, g, e);
      end
   end endtask
   task wr(input [7:0] a, b); begin
      @(negedge i_clk) i_daddr = a; i_dwdata = b; i_dwr = 1; i_drd = 0;
      @(negedge i_clk) i_dwr = 0;
   end endtask
   task rd(input [7:0] a, e); begin
      i_daddr = a; i_drd = 1; #1 cmp(o_win_rdata, e); @(negedge i_clk);
   end endtask
   task t_win; begin
      for (k = 0; k < 64; k = k + 21) begin
         wr(8'hc9, k[7:0]);
         rd(8'h40, {k[1:0], 6'h00} ^ {2'b10, k[5:0]});
         rd(8'h7f, {k[1:0], 6'h3f} ^ {2'b10, k[5:0]});
         cmp_addr(o_prom_addr, {k[5:0], 6'h3f});
      end
   end endtask
   task t_out; begin
      wr(8'hc8, 8'h00);
      rd(8'h7f, 8'h40);
      rd(8'h80, 8'h00);
      rd(8'h3f, 8'h00);
   end endtask
   task complete_run; begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   end endtask
   initial begin
      #250 i_nrst = 1;
      repeat (3) @(negedge i_clk);
      t_win;
      t_out;
      complete_run;
   end
endmodule

//--- testbench/prom_model.sv
// program memory model with address-derived bytes
`timescale 1ns/1ps
module prom_model(input wire [11:0] i_addr, output wire [7:0] o_data);
   assign o_data = i_addr[7:0] ^ {2'b10, i_addr[11:6]};
endmodule
